// File: bwdt_map.svh
// Contract
// - A nonzero loaded timeout starts the countdown from that value; the code ignores loads during the fire window.
// - Countdown reaching zero forces the configured expiry action.
// - Loading zero disables the watchdog and stops any countdown.
// - Expiry action is either cold reset or non-maskable interrupt, as configured.
// - Time unit of each count comes from a separate setup option.
`ifndef BWDT_MAP_SVH
`define BWDT_MAP_SVH
`define BWDT_SVC_CODE      8'h6F
`define BWDT_SUB_SET       8'h02
`define BWDT_COUNT_W       8
`define BWDT_COUNT_RST     8'h00
`define BWDT_CLK_HZ        20000000
`define BWDT_UNIT_SEC_NS   1000000000
`define BWDT_UNIT_MIN_NS   60000000000
`define BWDT_CLK_NS        50
`define BWDT_UNIT_SEC_CYC  (`BWDT_UNIT_SEC_NS / `BWDT_CLK_NS)
`define BWDT_RESET_PULSE   8
`define BWDT_NMI_PULSE     1
`define BWDT_SECS_PER_MIN  60
`endif

// File: bwdt_pkg.sv
`include "bwdt_map.svh"
package bwdt_pkg;
  typedef enum logic [2:0] {
    BWDT_OFF     = 3'b001,
    BWDT_RUN     = 3'b010,
    BWDT_FIRE    = 3'b100
  } bwdt_state_t;
  typedef enum logic {
    BWDT_ACT_RESET = 1'b0,
    BWDT_ACT_NMI   = 1'b1
  } bwdt_action_t;
endpackage

// File: bwdt_tick.sv
`include "bwdt_map.svh"
// Unit tick generator: one pulse per timeout unit
module bwdt_tick
  import bwdt_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `BWDT_UNIT_SEC_CYC
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic restart,
  input  wire logic unit_min,
  output logic      tick
);
  typedef struct packed {
    logic [31:0] cyc;
    logic [5:0]  sec;
    logic        tick;
  } bwdt_tick_st_t;
  bwdt_tick_st_t s;
  bwdt_tick_st_t next_s;
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (restart) begin
      next_s.cyc = 32'h0000_0000;
      next_s.sec = 6'h00;
    end else if (s.cyc == SEC_CYCLES - 1) begin
      next_s.cyc = 32'h0000_0000;
      // Minute unit stacks sixty second ticks
      if (!unit_min || s.sec == 6'(`BWDT_SECS_PER_MIN - 1)) begin
        next_s.sec = 6'h00;
        next_s.tick = 1'b1;
      end else begin
        next_s.sec = s.sec + 6'h01;
      end
    end else begin
      next_s.cyc = s.cyc + 32'h0000_0001;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end
  assign tick = s.tick;
endmodule

// File: bwdt_top.sv
`include "bwdt_map.svh"
// Countdown watchdog loaded through the firmware service call decode
module bwdt_top
  import bwdt_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `BWDT_UNIT_SEC_CYC,
  parameter int unsigned RST_PULSE  = `BWDT_RESET_PULSE
) (
  input  wire logic       CLOCK,
  input  wire logic       RST_B,
  input  wire logic       CE,
  input  wire logic       SVC_STB,
  input  wire logic [7:0] SVC_CODE,
  input  wire logic [7:0] SVC_SUB,
  input  wire logic [7:0] SVC_COUNT,
  input  wire logic       CFG_NMI,
  input  wire logic       CFG_UNIT_MIN,
  output logic            SYS_RESET,
  output logic            NMI,
  output logic            RUNNING,
  output logic [7:0]      COUNT
);
  typedef struct packed {
    bwdt_state_t state;
    logic [7:0]  count;
    logic [7:0]  hold;
    logic        sys_reset;
    logic        nmi;
    logic        running;
    logic [1:0]  nmi_sync;
    logic [1:0]  unit_sync;
  } bwdt_st_t;
  bwdt_st_t s;
  bwdt_st_t next_s;
  logic     load;
  logic     tick;
  assign load = SVC_STB && SVC_CODE == `BWDT_SVC_CODE && SVC_SUB == `BWDT_SUB_SET;
  bwdt_tick #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_tick (
    .clock    (CLOCK),
    .rst_b    (RST_B),
    .ce       (CE),
    .restart  (load),
    .unit_min (s.unit_sync[1]),
    .tick     (tick)
  );
  always_comb begin
    next_s = s;
    next_s.nmi = 1'b0;
    // Option straps come from board pins, so they cross two flops first
    next_s.nmi_sync  = {s.nmi_sync[0], CFG_NMI};
    next_s.unit_sync = {s.unit_sync[0], CFG_UNIT_MIN};
    case (s.state)
      BWDT_OFF: begin
        next_s.sys_reset = 1'b0;
        if (load && SVC_COUNT != 8'h00) begin
          next_s.count = SVC_COUNT;
          next_s.state = BWDT_RUN;
        end
      end
      BWDT_RUN: begin
        if (load) begin
          // A reload restarts the count; zero parks the timer
          next_s.count = SVC_COUNT;
          if (SVC_COUNT == 8'h00) begin
            next_s.state = BWDT_OFF;
          end
        end else if (tick) begin
          next_s.count = s.count - 8'h01;
          if (s.count == 8'h01) begin
            next_s.state = BWDT_FIRE;
            next_s.hold = 8'(RST_PULSE);
            if (s.nmi_sync[1]) begin
              next_s.nmi = 1'b1;
            end else begin
              next_s.sys_reset = 1'b1;
            end
          end
        end
      end
      BWDT_FIRE: begin
        // Reset pulse is stretched so board logic sees it; NMI is a single pulse
        if (s.hold <= 8'h01) begin
          next_s.sys_reset = 1'b0;
          next_s.state = BWDT_OFF;
        end else begin
          next_s.hold = s.hold - 8'h01;
        end
      end
      default: begin
        next_s.state = BWDT_OFF;
      end
    endcase
    // Registered so the pin does not glitch while the state decodes
    next_s.running = next_s.state == BWDT_RUN;
  end
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      s.state     <= BWDT_OFF;
      s.count     <= `BWDT_COUNT_RST;
      s.hold      <= 8'h00;
      s.sys_reset <= 1'b0;
      s.nmi       <= 1'b0;
      s.running   <= 1'b0;
      s.nmi_sync  <= 2'h0;
      s.unit_sync <= 2'h0;
    end else if (CE) begin
      s <= next_s;
    end
  end
  assign SYS_RESET = s.sys_reset;
  assign NMI       = s.nmi;
  assign RUNNING   = s.running;
  assign COUNT     = s.count;

  property p_start;
    @(posedge CLOCK) disable iff (!RST_B)
      (CE && s.state == BWDT_OFF && load && SVC_COUNT != 8'h00) |=> RUNNING && COUNT == $past(SVC_COUNT);
  endproperty
  a_start: assert property (p_start) else $error("nonzero load did not start");
  property p_zero;
    @(posedge CLOCK) disable iff (!RST_B)
      (CE && load && SVC_COUNT == 8'h00 && s.state != BWDT_FIRE) |=>
        !RUNNING ##1 !SYS_RESET && !NMI;
  endproperty
  a_zero: assert property (p_zero) else $error("zero load did not disable");
  property p_expire;
    @(posedge CLOCK) disable iff (!RST_B)
      (CE && RUNNING && tick && !load && COUNT == 8'h01) |=> (SYS_RESET ^ NMI);
  endproperty
  a_expire: assert property (p_expire) else $error("expiry took no action");
  property p_action;
    @(posedge CLOCK) disable iff (!RST_B)
      $rose(NMI) |-> $past(s.nmi_sync[1]) && !SYS_RESET;
  endproperty
  a_action: assert property (p_action) else $error("nmi without nmi option");
  property p_reload;
    @(posedge CLOCK) disable iff (!RST_B)
      (CE && RUNNING && load && SVC_COUNT != 8'h00) |=> COUNT == $past(SVC_COUNT);
  endproperty
  a_reload: assert property (p_reload) else $error("reload did not restart");
  property p_reset_state;
    @(posedge CLOCK) $rose(RST_B) |-> !RUNNING && COUNT == 8'h00 && !SYS_RESET;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("not idle after reset");
  property p_bad_code;
    @(posedge CLOCK) disable iff (!RST_B)
      (SVC_STB && SVC_CODE != `BWDT_SVC_CODE && !tick && CE) |=> COUNT == $past(COUNT);
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("foreign call changed count");
  property p_hold;
    @(posedge CLOCK) disable iff (!RST_B)
      !CE |=> $stable(COUNT) && $stable(RUNNING);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved while frozen");

  // Expiry action and pulse shape
  property p_nmi_pulse;
    @(posedge CLOCK) disable iff (!RST_B)
      (CE && NMI) |=> !NMI;
  endproperty
  a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi longer than one cycle");
  property p_one_action;
    @(posedge CLOCK) disable iff (!RST_B)
      !(SYS_RESET && NMI);
  endproperty
  a_one_action: assert property (p_one_action) else $error("reset and nmi together");
  property p_cold_reset;
    @(posedge CLOCK) disable iff (!RST_B)
      $rose(SYS_RESET) |-> !$past(s.nmi_sync[1]) && !NMI;
  endproperty
  a_cold_reset: assert property (p_cold_reset) else $error("reset with nmi option");
  property p_off_quiet;
    @(posedge CLOCK) disable iff (!RST_B)
      (s.state == BWDT_OFF) |-> !SYS_RESET && !NMI && !RUNNING;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("disabled timer is active");
  property p_run_nonzero;
    @(posedge CLOCK) disable iff (!RST_B)
      RUNNING |-> COUNT != 8'h00;
  endproperty
  a_run_nonzero: assert property (p_run_nonzero) else $error("running with zero count");

  // Countdown steps
  property p_tick_dec;
    @(posedge CLOCK) disable iff (!RST_B)
      (CE && RUNNING && tick && !load && COUNT != 8'h01) |=>
        RUNNING && COUNT == $past(COUNT) - 8'h01;
  endproperty
  a_tick_dec: assert property (p_tick_dec) else $error("unit tick did not count down");
  property p_idle_hold;
    @(posedge CLOCK) disable iff (!RST_B)
      (CE && RUNNING && !tick && !load) |=> RUNNING && $stable(COUNT);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("count moved without a tick");
  property p_load_restart;
    @(posedge CLOCK) disable iff (!RST_B)
      (CE && load) |=> !tick;
  endproperty
  a_load_restart: assert property (p_load_restart) else $error("load kept the old unit phase");
  property p_reload_run;
    @(posedge CLOCK) disable iff (!RST_B)
      (CE && RUNNING && load && SVC_COUNT != 8'h00) |=> RUNNING && !SYS_RESET && !NMI;
  endproperty
  a_reload_run: assert property (p_reload_run) else $error("reload stopped the timer");

  // Fire window: count parked at zero, calls ignored until the reset-pulse window ends, for either action
  property p_fire_zero;
    @(posedge CLOCK) disable iff (!RST_B)
      (s.state == BWDT_FIRE) |-> COUNT == 8'h00 && !RUNNING;
  endproperty
  a_fire_zero: assert property (p_fire_zero) else $error("fired with count left");
  property p_fire_hold;
    @(posedge CLOCK) disable iff (!RST_B)
      (CE && s.state == BWDT_FIRE && s.hold > 8'h01) |=>
        s.state == BWDT_FIRE && $stable(SYS_RESET);
  endproperty
  a_fire_hold: assert property (p_fire_hold) else $error("reset pulse cut short");
  property p_fire_exit;
    @(posedge CLOCK) disable iff (!RST_B)
      (CE && s.state == BWDT_FIRE && s.hold <= 8'h01) |=> s.state == BWDT_OFF && !SYS_RESET;
  endproperty
  a_fire_exit: assert property (p_fire_exit) else $error("reset pulse did not end");
  property p_fire_ignore;
    @(posedge CLOCK) disable iff (!RST_B)
      (CE && s.state == BWDT_FIRE && load) |=> !RUNNING;
  endproperty
  a_fire_ignore: assert property (p_fire_ignore) else $error("load taken while firing");
  property p_sub_ignore;
    @(posedge CLOCK) disable iff (!RST_B)
      (CE && SVC_STB && SVC_CODE == `BWDT_SVC_CODE && SVC_SUB != `BWDT_SUB_SET && !tick) |=>
        COUNT == $past(COUNT) && $stable(RUNNING);
  endproperty
  a_sub_ignore: assert property (p_sub_ignore) else $error("foreign sub-function acted");
endmodule

// File: bwdt_tb.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock = 0;
  logic       rst_b = 0;
  logic       stb   = 0;
  logic       nmi_c = 0;
  logic       umin  = 0;
  logic       ce    = 1;
  logic [7:0] code  = 0;
  logic [7:0] sub   = 0;
  logic [7:0] cnt   = 0;
  logic [7:0] rnd   = 8'h10;
  logic [7:0] count;
  logic       sres;
  logic       nmi;
  logic       run;
  int         err_count = 0;
  int         checked   = 0;
  int         n;
  localparam int SEC = 4;

  bwdt_top #(.SEC_CYCLES(SEC), .RST_PULSE(8)) i_dut (
    .CLOCK(clock), .RST_B(rst_b), .CE(ce), .SVC_STB(stb), .SVC_CODE(code),
    .SVC_SUB(sub), .SVC_COUNT(cnt), .CFG_NMI(nmi_c), .CFG_UNIT_MIN(umin),
    .SYS_RESET(sres), .NMI(nmi), .RUNNING(run), .COUNT(count));

  initial forever #25 clock = ~clock;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Cycles from the end of a load call to the expiry pulse
  function automatic int fire_cycles(input int units, input logic minutes);
    return units * (minutes ? 60 : 1) * SEC;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic call(input logic [7:0] c, input logic [7:0] s, input logic [7:0] v);
    @(posedge clock);
    stb  <= 1;
    code <= c;
    sub  <= s;
    cnt  <= v;
    @(posedge clock);
    stb <= 0;
    @(posedge clock);
    #1;
  endtask

  // Expiry lands on an exact cycle because every load clears the prescaler
  task automatic expire(input int per, input logic use_nmi);
    int t;
    int w;
    t = 0;
    w = 0;
    while (!(sres === 1 || nmi === 1) && t < 2000) begin
      @(posedge clock);
      #1;
      t++;
    end
    chk("expiry time", t, per);
    chk("nmi", nmi, use_nmi);
    chk("cold reset", sres, !use_nmi);
    while (sres === 1 || nmi === 1) begin
      @(posedge clock);
      #1;
      w++;
    end
    chk("pulse width", w, use_nmi ? 1 : 8);
    // After an interrupt the unit still sits out the full pulse window
    if (use_nmi) begin
      repeat (7) @(posedge clock);
      #1;
    end
    chk("running", run, 0);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #500000;
    err_count++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1;
    @(posedge clock);
    #1;
    chk("count", count, 0);
    chk("running", run, 0);
    for (int i = 0; i < 6; i++) begin
      rnd   = lfsr(rnd);
      n     = rnd % 3 + 1;
      nmi_c <= rnd[4];
      call(8'h6F, 8'h02, n[7:0]);
      chk("count", count, n);
      chk("running", run, 1);
      expire(fire_cycles(n, 1'b0), rnd[4]);
    end
    $display("expiry test done");
    call(8'h6F, 8'h02, 8'h02);
    // Refresh after 7 cycles against an 8-cycle timeout keeps a margin
    repeat (5) @(posedge clock);
    call(8'h6F, 8'h02, 8'h02);
    chk("count", count, 2);
    call(8'h6F, 8'h02, 8'h00);
    repeat (20) @(posedge clock);
    #1;
    chk("running", run, 0);
    chk("reset", sres | nmi, 0);
    call(lfsr(rnd) | 8'h80, 8'h02, 8'h05);
    call(8'h6F, 8'h03, 8'h05);
    chk("running", run, 0);
    call(8'h6F, 8'h02, 8'hFF);
    chk("count", count, 8'hFF);
    ce <= 0;
    repeat (20) @(posedge clock);
    #1;
    chk("frozen count", count, 8'hFF);
    chk("frozen running", run, 1);
    ce <= 1;
    call(8'h6F, 8'h02, 8'h00);
    chk("running", run, 0);
    call(8'h6F, 8'h02, 8'h05);
    rst_b <= 0;
    repeat (2) @(posedge clock);
    rst_b <= 1;
    @(posedge clock);
    #1;
    chk("count", count, 0);
    chk("running", run, 0);
    $display("reload disable test done");
    umin <= 1;
    call(8'h6F, 8'h02, 8'h01);
    repeat (100) @(posedge clock);
    #1;
    chk("count", count, 1);
    expire(fire_cycles(1, 1'b1) - 100, nmi_c);
    $display("unit test done");
    stop_test();
  end
endmodule
